// ==== dcs_pkg.sv ====
// Purpose: Shared constants and types for the dual oscillator clock selector
// Assumes: Register indices as printed; byte address is four times the index
// Notes: Wait counts are in oscillator ticks, not system clock cycles
package dcs_pkg;

	// ----------------------------------------------------------------
	// Register map (word indices)
	// ----------------------------------------------------------------
	localparam logic [29:0] IDX_SRC = 30'h0000_5060;
	localparam logic [29:0] IDX_CTL = 30'h0000_5061;
	localparam logic [29:0] IDX_STAT = 30'h0000_5070;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int SRC_SEL_BIT = 0;
	localparam int CTL_MAIN_EN_BIT = 0;
	localparam int CTL_SUB_EN_BIT = 1;
	localparam int CTL_WAIT_LSB = 4;
	localparam int STAT_MAIN_RDY_BIT = 0;
	localparam int STAT_SUB_RDY_BIT = 1;
	localparam int STAT_ON_SUB_BIT = 2;
	localparam int STAT_HALT_BIT = 3;
	localparam logic RST_MAIN_EN = 1'b1;
	localparam logic RST_SUB_EN = 1'b0;
	localparam logic [1:0] RST_WAIT_SEL = 2'h0;
	localparam logic RST_SRC_SEL = 1'b0;

	// ----------------------------------------------------------------
	// Stabilization wait counts
	// ----------------------------------------------------------------
	localparam int WAIT_W = 11;
	localparam logic [WAIT_W-1:0] MAIN_WAIT_C0 = 11'h400;
	localparam logic [WAIT_W-1:0] MAIN_WAIT_C1 = 11'h200;
	localparam logic [WAIT_W-1:0] MAIN_WAIT_C2 = 11'h100;
	localparam logic [WAIT_W-1:0] MAIN_WAIT_C3 = 11'h080;
	localparam logic [WAIT_W-1:0] SUB_WAIT = 11'h100;
	localparam logic [WAIT_W-1:0] WAIT_MAX = 11'h400;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_MAIN = 2'b00,
		TO_SUB = 2'b01,
		SRC_SUB = 2'b10,
		TO_MAIN = 2'b11
	} dcs_src_e;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} dcs_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} dcs_wb_rsp_s;

	typedef struct packed {
		logic mainRun;
		logic subRun;
		logic mainGate;
		logic subGate;
		logic sysHalt;
		logic coreHold;
	} dcs_clk_s;

	function automatic logic [WAIT_W-1:0] mainWaitCount(input logic [1:0] code);
		logic [WAIT_W-1:0] r;
		r = MAIN_WAIT_C0;
		unique case (code)
			2'h0: r = MAIN_WAIT_C0;
			2'h1: r = MAIN_WAIT_C1;
			2'h2: r = MAIN_WAIT_C2;
			2'h3: r = MAIN_WAIT_C3;
		endcase
		return r;
	endfunction

endpackage

// ==== dual_oscillator_clock_select.sv ====
// Purpose: Oscillator enables, stabilization waits and glitch-free source switching
// Assumes: Oscillator edges arrive as one-cycle ticks synchronous to clk_sys
// Notes: Gate outputs drive the clock gating cells of the system clock mux
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
module dual_oscillator_clock_select (
	// System
	input wire logic clk_sys,
	input wire logic rstn,
	// Register bus
	input wire dcs_pkg::dcs_wb_req_s wbReq,
	output dcs_pkg::dcs_wb_rsp_s wbRsp,
	// Oscillator ticks and core state
	input wire logic mainOscTick,
	input wire logic subOscTick,
	input wire logic coreSleep,
	// Clock control
	output dcs_pkg::dcs_clk_s clkCtl
);
	import dcs_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic mainOscEnable;
	logic subOscEnable;
	logic [1:0] mainOscWaitSelect;
	logic systemClockSourceSelect;
	logic ack;
	logic [31:0] rdDat;
	logic [1:0] oscRun;
	logic [1:0] oscTick;
	logic [1:0] oscReady;
	logic [WAIT_W-1:0] waitCnt [1:0];
	logic [WAIT_W-1:0] waitTarget [1:0];
	logic gateMain;
	logic gateSub;
	logic sysHalt;
	dcs_src_e srcState;
	logic busHit;
	logic wrLane0;
	logic [29:0] wordIdx;

	assign wordIdx = wbReq.adr[31:2];
	assign busHit = wbReq.cyc && wbReq.stb && !ack;
	// Writes land at the edge that samples ack, while the request still stands
	assign wrLane0 = wbReq.cyc && wbReq.stb && ack && wbReq.we && wbReq.sel[0];

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// One wait state; unmapped reads return zero, unmapped writes are dropped
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ack <= 1'b0;
		end else begin
			ack <= busHit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdDat <= 32'h0000_0000;
		end else if (busHit) begin
			rdDat <= 32'h0000_0000;
			if (wordIdx == IDX_SRC) begin
				rdDat[SRC_SEL_BIT] <= systemClockSourceSelect;
			end else if (wordIdx == IDX_CTL) begin
				rdDat[CTL_MAIN_EN_BIT] <= mainOscEnable;
				rdDat[CTL_SUB_EN_BIT] <= subOscEnable;
				rdDat[CTL_WAIT_LSB +: 2] <= mainOscWaitSelect;
			end else if (wordIdx == IDX_STAT) begin
				rdDat[STAT_MAIN_RDY_BIT] <= oscReady[0];
				rdDat[STAT_SUB_RDY_BIT] <= oscReady[1];
				rdDat[STAT_ON_SUB_BIT] <= (srcState == SRC_SUB);
				rdDat[STAT_HALT_BIT] <= sysHalt;
			end
		end
	end

	assign wbRsp.ack = ack;
	assign wbRsp.dat = rdDat;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// A stop request for the active source is refused, the bit stays set
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mainOscEnable <= RST_MAIN_EN;
			subOscEnable <= RST_SUB_EN;
			mainOscWaitSelect <= RST_WAIT_SEL;
		end else if (wrLane0 && wordIdx == IDX_CTL) begin
			mainOscEnable <= wbReq.dat[CTL_MAIN_EN_BIT] || (srcState != SRC_SUB);
			subOscEnable <= wbReq.dat[CTL_SUB_EN_BIT] || (srcState != SRC_MAIN);
			mainOscWaitSelect <= wbReq.dat[CTL_WAIT_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			systemClockSourceSelect <= RST_SRC_SEL;
		end else if (wrLane0 && wordIdx == IDX_SRC) begin
			systemClockSourceSelect <= wbReq.dat[SRC_SEL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Oscillator enables
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			oscRun <= 2'h0;
		end else begin
			oscRun[0] <= mainOscEnable && !coreSleep;
			oscRun[1] <= subOscEnable && !coreSleep;
		end
	end

	// ----------------------------------------------------------------
	// Stabilization wait counters
	// ----------------------------------------------------------------
	assign oscTick = {subOscTick, mainOscTick};
	assign waitTarget[0] = mainWaitCount(mainOscWaitSelect);
	assign waitTarget[1] = SUB_WAIT;

	// Counter clears whenever the oscillator is off, so every start waits again
	// Comparing with >= lets software shorten the wait while counting
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gWait
			always_ff @(posedge clk_sys) begin
				if (!rstn || !oscRun[gi]) begin
					waitCnt[gi] <= '0;
				end else if (oscTick[gi] && waitCnt[gi] < WAIT_MAX) begin
					waitCnt[gi] <= waitCnt[gi] + 11'h001;
				end
			end
			assign oscReady[gi] = oscRun[gi] && (waitCnt[gi] >= waitTarget[gi]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Glitch-free source switch
	// ----------------------------------------------------------------
	// Old gate drops on an old-clock tick, or at once while that clock is not ready; new gate rises on a new-clock tick;
	// between the two no gate is open, trading a short halt for clean pulses
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			srcState <= SRC_MAIN;
			gateMain <= 1'b1;
			gateSub <= 1'b0;
		end else begin
			unique case (srcState)
				SRC_MAIN: begin
					if (systemClockSourceSelect && (!oscReady[0] || mainOscTick)) begin
						gateMain <= 1'b0;
						srcState <= TO_SUB;
					end
				end
				TO_SUB: begin
					if (!systemClockSourceSelect && oscReady[0] && mainOscTick) begin
						gateMain <= 1'b1;
						srcState <= SRC_MAIN;
					end else if (systemClockSourceSelect && oscReady[1] && subOscTick) begin
						gateSub <= 1'b1;
						srcState <= SRC_SUB;
					end
				end
				SRC_SUB: begin
					if (!systemClockSourceSelect && (!oscReady[1] || subOscTick)) begin
						gateSub <= 1'b0;
						srcState <= TO_MAIN;
					end
				end
				TO_MAIN: begin
					if (systemClockSourceSelect && oscReady[1] && subOscTick) begin
						gateSub <= 1'b1;
						srcState <= SRC_SUB;
					end else if (!systemClockSourceSelect && oscReady[0] && mainOscTick) begin
						gateMain <= 1'b1;
						srcState <= SRC_MAIN;
					end
				end
			endcase
		end
	end

	// Halted whenever the open gate belongs to a clock still in its wait
	assign sysHalt = !((gateMain && oscReady[0]) || (gateSub && oscReady[1]));

	assign clkCtl.mainRun = oscRun[0];
	assign clkCtl.subRun = oscRun[1];
	assign clkCtl.mainGate = gateMain && oscReady[0];
	assign clkCtl.subGate = gateSub && oscReady[1];
	assign clkCtl.sysHalt = sysHalt;
	assign clkCtl.coreHold = sysHalt;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_reset_main_src: assert property (@(posedge clk_sys)
		$rose(rstn) |-> srcState == SRC_MAIN && gateMain && !gateSub)
		else $error("main is not the source after reset");

	a_main_wait_done: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(oscReady[0]) |-> waitCnt[0] == mainWaitCount(mainOscWaitSelect) || $changed(mainOscWaitSelect))
		else $error("main ready before its wait count");

	a_sub_wait_done: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(oscReady[1]) |-> waitCnt[1] == 11'h100)
		else $error("sub ready before 256 ticks");

	a_sleep_stops_osc: assert property (@(posedge clk_sys) disable iff (!rstn)
		coreSleep |=> !oscRun[0] && !oscRun[1])
		else $error("oscillator runs during sleep");

	a_main_held_on: assert property (@(posedge clk_sys) disable iff (!rstn)
		srcState != SRC_SUB |-> mainOscEnable)
		else $error("main disabled while in use");

	a_sub_held_on: assert property (@(posedge clk_sys) disable iff (!rstn)
		srcState != SRC_MAIN |-> subOscEnable || srcState == TO_SUB)
		else $error("sub disabled while in use");

	a_gates_exclusive: assert property (@(posedge clk_sys) disable iff (!rstn)
		!(gateMain && gateSub))
		else $error("both clock gates open");

	a_sub_wait_halts: assert property (@(posedge clk_sys) disable iff (!rstn)
		srcState == TO_SUB && !oscReady[1] |-> sysHalt)
		else $error("system clock runs before sub is ready");

	a_core_held_boot: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |-> sysHalt [*8])
		else $error("core released too early after reset");

	a_ack_single: assert property (@(posedge clk_sys) disable iff (!rstn)
		ack |=> !ack)
		else $error("ack held longer than one cycle");

	a_ack_answers: assert property (@(posedge clk_sys) disable iff (!rstn)
		busHit |=> ack)
		else $error("bus request not answered in one cycle");

	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		busHit && wordIdx != IDX_SRC && wordIdx != IDX_CTL && wordIdx != IDX_STAT |=> rdDat == 32'h0000_0000)
		else $error("unmapped read returned data");

	a_reset_ctl_values: assert property (@(posedge clk_sys)
		$rose(rstn) |-> mainOscEnable && !subOscEnable && mainOscWaitSelect == 2'h0)
		else $error("control bits wrong after reset");

	a_main_run_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
		$past(rstn) |-> oscRun[0] == ($past(mainOscEnable) && !$past(coreSleep)))
		else $error("main run does not follow enable and sleep");

	a_sub_run_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
		$past(rstn) |-> oscRun[1] == ($past(subOscEnable) && !$past(coreSleep)))
		else $error("sub run does not follow enable and sleep");

	a_sleep_halts: assert property (@(posedge clk_sys) disable iff (!rstn)
		coreSleep |=> sysHalt)
		else $error("system clock runs during sleep");

	a_main_stop_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		wrLane0 && wordIdx == IDX_CTL && srcState != SRC_SUB |=> mainOscEnable)
		else $error("main stopped while it may be in use");

	a_sub_stop_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
		wrLane0 && wordIdx == IDX_CTL && srcState != SRC_MAIN |=> subOscEnable)
		else $error("sub stopped while it may be in use");

	a_src_sel_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		wrLane0 && wordIdx == IDX_SRC |=> systemClockSourceSelect == $past(wbReq.dat[SRC_SEL_BIT]))
		else $error("source select does not take the written value");

	a_main_gate_ready: assert property (@(posedge clk_sys) disable iff (!rstn)
		clkCtl.mainGate |-> oscRun[0] && waitCnt[0] >= mainWaitCount(mainOscWaitSelect))
		else $error("main clock passed before its wait");

	a_sub_gate_ready: assert property (@(posedge clk_sys) disable iff (!rstn)
		clkCtl.subGate |-> oscRun[1] && waitCnt[1] >= SUB_WAIT)
		else $error("sub clock passed before its wait");

	a_main_wait_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
		!oscRun[0] |=> waitCnt[0] == 11'h000)
		else $error("main wait not restarted after a stop");

	a_sub_wait_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
		!oscRun[1] |=> waitCnt[1] == 11'h000)
		else $error("sub wait not restarted after a stop");

	a_main_gate_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(gateMain) |-> $past(mainOscTick) || !$past(oscReady[0]))
		else $error("main gate closed off a main tick");

	a_main_gate_open: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(gateMain) |-> $past(mainOscTick) && $past(oscReady[0]))
		else $error("main gate opened off a main tick");

	a_sub_gate_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(gateSub) |-> $past(subOscTick) || !$past(oscReady[1]))
		else $error("sub gate closed off a sub tick");

	a_sub_gate_open: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(gateSub) |-> $past(subOscTick) && $past(oscReady[1]))
		else $error("sub gate opened off a sub tick");

	// ----------------------------------------------------------------
	// Boot check
	// ----------------------------------------------------------------
	// Own tick count, apart from the wait counter that it guards
	logic [WAIT_W-1:0] bootTicks;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bootTicks <= '0;
		end else if (mainOscTick && oscRun[0] && bootTicks < MAIN_WAIT_C0) begin
			bootTicks <= bootTicks + 11'h001;
		end
	end

	a_core_held_1024: assert property (@(posedge clk_sys) disable iff (!rstn)
		bootTicks < MAIN_WAIT_C0 |-> clkCtl.coreHold)
		else $error("core released before 1024 main ticks");

endmodule // dual_oscillator_clock_select

// ==== dual_oscillator_clock_select_tb_top.sv ====
// Purpose: Self-checking bench for the dual oscillator clock selector
// Assumes: Oscillator ticks are driven by the bench, one pulse every other cycle
// Notes: Tick counts stop one tick short of the boot, sleep-restart and sub wait targets, then step across them
`timescale 1ns/1ns
module dual_oscillator_clock_select_tb_top;
	import dcs_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	dcs_wb_req_s wbReq = '0;
	dcs_wb_rsp_s wbRsp;
	logic mainOscTick = 1'b0;
	logic subOscTick = 1'b0;
	logic coreSleep = 1'b0;
	dcs_clk_s clkCtl;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [1:0] code;

	dual_oscillator_clock_select dut_u (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.wbReq(wbReq),
		.wbRsp(wbRsp),
		.mainOscTick(mainOscTick),
		.subOscTick(subOscTick),
		.coreSleep(coreSleep),
		.clkCtl(clkCtl)
	);

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle; held until the rising edge that samples ack, released right there
	// A hang is left to the cycle watchdog
	task automatic bus(input logic we, input logic [29:0] idx, input logic [31:0] wd, output logic [31:0] dat);
		@(posedge clk_sys);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {idx, 2'b00}, dat: wd};
		do begin
			@(posedge clk_sys);
		end while (wbRsp.ack !== 1'b1);
		dat = wbRsp.dat;
		wbReq <= '0;
	endtask

	task automatic ticks(input int n, input logic m, input logic s);
		repeat (n) begin
			@(posedge clk_sys);
			mainOscTick <= m;
			subOscTick <= s;
			@(posedge clk_sys);
			mainOscTick <= 1'b0;
			subOscTick <= 1'b0;
		end
		@(negedge clk_sys);
	endtask

	function automatic int mainTarget(input logic [1:0] c);
		return 1024 >> c;
	endfunction

	function automatic logic [31:0] bit1(input logic b);
		return {31'h0, b};
	endfunction

	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	always @(negedge clk_sys) begin
		if (rstn) begin
			chk(bit1(clkCtl.mainGate & clkCtl.subGate), 32'h0);
			chk(bit1(clkCtl.coreHold), bit1(!(clkCtl.mainGate | clkCtl.subGate)));
		end
	end

	// Hang guard: whole run needs well under the 40000-cycle limit
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(35227));
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		bus(1'b0, IDX_SRC, 32'h0, rd);
		chk(rd, 32'h0);
		bus(1'b0, IDX_CTL, 32'h0, rd);
		chk(rd, 32'h1);
		chk(bit1(clkCtl.mainRun), 32'h1);
		ticks(1023, 1'b1, 1'b0);
		chk(bit1(clkCtl.sysHalt), 32'h1);
		ticks(1, 1'b1, 1'b0);
		chk(bit1(clkCtl.mainGate), 32'h1);
		chk(bit1(clkCtl.coreHold), 32'h0);
		bus(1'b1, IDX_CTL, 32'h0, rd);
		bus(1'b0, IDX_CTL, 32'h0, rd);
		chk(rd, 32'h1);
		bus(1'b1, IDX_SRC + 30'h2 + 30'($urandom % 8), $urandom, rd);
		bus(1'b0, IDX_SRC + 30'h2 + 30'($urandom % 8), 32'h0, rd);
		chk(rd, 32'h0);
		// Sleep is the only way to restart main while it is the source
		for (int k = 1; k < 4; k++) begin
			code = 2'(k);
			bus(1'b1, IDX_CTL, {26'h0, code, 4'h1}, rd);
			@(posedge clk_sys);
			coreSleep <= 1'b1;
			ticks(3, 1'b1, 1'b1);
			chk(bit1(clkCtl.mainRun), 32'h0);
			chk(bit1(clkCtl.subRun), 32'h0);
			@(posedge clk_sys);
			coreSleep <= 1'b0;
			ticks(mainTarget(code) - 1, 1'b1, 1'b0);
			chk(bit1(clkCtl.sysHalt), 32'h1);
			ticks(1, 1'b1, 1'b0);
			chk(bit1(clkCtl.mainGate), 32'h1);
		end
		bus(1'b1, IDX_CTL, 32'h33, rd);
		repeat (2) @(negedge clk_sys);
		chk(bit1(clkCtl.subRun), 32'h1);
		bus(1'b1, IDX_SRC, 32'h1, rd);
		ticks(4, 1'b1, 1'b1);
		chk(bit1(clkCtl.sysHalt), 32'h1);
		chk(bit1(clkCtl.mainGate), 32'h0);
		ticks(251, 1'b0, 1'b1);
		chk(bit1(clkCtl.subGate), 32'h0);
		ticks(2, 1'b0, 1'b1);
		chk(bit1(clkCtl.subGate), 32'h1);
		chk(bit1(clkCtl.sysHalt), 32'h0);
		bus(1'b0, IDX_STAT, 32'h0, rd);
		chk(rd, 32'h7);
		bus(1'b1, IDX_CTL, 32'h30, rd);
		bus(1'b0, IDX_CTL, 32'h0, rd);
		chk(rd, 32'h32);
		chk(bit1(clkCtl.mainRun), 32'h0);
		bus(1'b1, IDX_CTL, 32'h33, rd);
		ticks(132, 1'b1, 1'b1);
		bus(1'b1, IDX_SRC, 32'h0, rd);
		ticks(4, 1'b1, 1'b1);
		chk(bit1(clkCtl.mainGate), 32'h1);
		chk(bit1(clkCtl.subGate), 32'h0);
		bus(1'b1, IDX_CTL, 32'h31, rd);
		bus(1'b0, IDX_CTL, 32'h0, rd);
		chk(rd, 32'h31);
		chk(bit1(clkCtl.subRun), 32'h0);
		final_report();
	end

endmodule // dual_oscillator_clock_select_tb_top
